//--- pkg/spims_pkg.sv
// Shared constants and state types for the SPI master/slave port
package spims_pkg;

    // Register byte addresses on the Wishbone bus
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h4;
    localparam logic [3:0] ADDR_DATA    = 4'h8;
    localparam logic [3:0] ADDR_PINCFG  = 4'hC;

    // spi_control fields
    localparam int CTRL_IRQ_ENABLE  = 7;
    localparam int CTRL_PORT_ENABLE = 6;
    localparam int CTRL_BIT_ORDER   = 5;
    localparam int CTRL_MASTER      = 4;
    localparam int CTRL_POLARITY    = 3;
    localparam int CTRL_PHASE       = 2;
    localparam int CTRL_RATE_HI     = 1;
    localparam int CTRL_RATE_LO     = 0;

    // spi_status fields
    localparam int STAT_DONE   = 7;
    localparam int STAT_WRITE_COLLISION_FLAG   = 6;
    localparam int STAT_DOUBLE = 0;

    // pin_config fields
    localparam int PIN_SS_OUT    = 0;
    localparam int PIN_MOSI_OUT  = 1;
    localparam int PIN_SCK_OUT   = 2;
    localparam int PIN_MISO_OUT  = 3;
    localparam int PIN_SS_LEVEL  = 4;
    localparam int PIN_GLOBAL_IE = 7;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PINCFG_RESET  = 8'h00;
    localparam logic       FLAG_RESET    = 1'b0;

    // Half SCK period in system clocks: divide by 4,16,64,128 or 2,8,32,64
    localparam logic [5:0] HALF_DIV4   = 6'h02;
    localparam logic [5:0] HALF_DIV16  = 6'h08;
    localparam logic [5:0] HALF_DIV64  = 6'h20;
    // Only half period that needs a seventh bit
    localparam logic [6:0] HALF_DIV128 = 7'h40;
    localparam logic [5:0] HALF_DIV2   = 6'h01;
    localparam logic [5:0] HALF_DIV8   = 6'h04;
    localparam logic [5:0] HALF_DIV32  = 6'h10;

    // Byte framing
    localparam logic [3:0] LAST_EDGE   = 4'hF;
    localparam logic [2:0] LAST_SAMPLE = 3'h7;

    typedef struct packed {
        logic [6:0] cnt;
        logic       tick;
    } spims_div_type;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
        logic [7:0] ctrl;
        logic       dbl;
        logic       done;
        logic       write_collision_flag;
        logic       arm_done;
        logic       arm_write_collision_flag;
        logic [7:0] pincfg;
        logic [7:0] sr;
        logic [7:0] rx_buf;
        logic       out_bit;
        logic       running;
        logic [3:0] edge_cnt;
        logic [2:0] bit_cnt;
        logic       sck_out;
        logic       sck_prev;
        logic       ss_prev;
    } spims_state_type;

endpackage

//--- core/spims_rate_div.sv
// Master SCK rate divider: one tick per half SCK period
`timescale 1ns/1ps
module spims_rate_div (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // Control
    input  wire logic       i_run,
    input  wire logic [1:0] i_rate,
    input  wire logic       i_double,
    // Half-period tick
    output logic            o_tick
);

    spims_pkg::spims_div_type state_ff;
    spims_pkg::spims_div_type nxt_state;
    logic [6:0]               half;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        case ({i_double, i_rate})
            3'h0:    half = {1'b0, spims_pkg::HALF_DIV4};
            3'h1:    half = {1'b0, spims_pkg::HALF_DIV16};
            3'h2:    half = {1'b0, spims_pkg::HALF_DIV64};
            3'h3:    half = spims_pkg::HALF_DIV128;
            3'h4:    half = {1'b0, spims_pkg::HALF_DIV2};
            3'h5:    half = {1'b0, spims_pkg::HALF_DIV8};
            3'h6:    half = {1'b0, spims_pkg::HALF_DIV32};
            default: half = {1'b0, spims_pkg::HALF_DIV64};
        endcase
    end

    always_comb begin
        nxt_state      = state_ff;
        nxt_state.tick = 1'b0;
        if (!i_run) begin
            nxt_state.cnt = 7'h00;
        end else if (state_ff.cnt >= half - 7'h01) begin
            nxt_state.cnt  = 7'h00;
            nxt_state.tick = 1'b1;
        end else begin
            nxt_state.cnt = state_ff.cnt + 7'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_tick = state_ff.tick;

    ////////////////////////////////////////////////////////////////////////
    AST_TICK_ONLY_RUNNING: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_run ##1 !i_run |-> !o_tick)
        else $error("Rate tick while divider stopped");

endmodule

//--- core/spims_port.sv
// SPI master/slave port with Wishbone register access
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module spims_port (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    // Interrupt request and vector acknowledge
    input  wire logic        i_irq_vector_taken,
    output logic             o_irq,
    // SCK pin
    input  wire logic        i_sck,
    output logic             o_sck,
    output logic             o_sck_oe_n,
    // MOSI pin
    input  wire logic        i_mosi,
    output logic             o_mosi,
    output logic             o_mosi_oe_n,
    // MISO pin
    input  wire logic        i_miso,
    output logic             o_miso,
    output logic             o_miso_oe_n,
    // Slave select pin
    input  wire logic        i_ss_n,
    output logic             o_ss_n,
    output logic             o_ss_n_oe_n
);

    spims_pkg::spims_state_type state_ff;
    spims_pkg::spims_state_type nxt_state;
    logic                       tick;
    logic                       port_en;
    logic                       is_master;
    logic                       lsb_first;
    logic                       clock_polarity_bit;
    logic                       clock_phase_bit;
    logic                       ss_is_out;
    logic                       global_ie;

    function automatic logic top_bit(input logic [7:0] sr, input logic lsb);
        top_bit = lsb ? sr[0] : sr[7];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic lsb,
                                            input logic b);
        shift_in = lsb ? {b, sr[7:1]} : {sr[6:0], b};
    endfunction

    assign port_en   = state_ff.ctrl[spims_pkg::CTRL_PORT_ENABLE];
    assign is_master = state_ff.ctrl[spims_pkg::CTRL_MASTER];
    assign lsb_first = state_ff.ctrl[spims_pkg::CTRL_BIT_ORDER];
    assign clock_polarity_bit      = state_ff.ctrl[spims_pkg::CTRL_POLARITY];
    assign clock_phase_bit      = state_ff.ctrl[spims_pkg::CTRL_PHASE];
    assign ss_is_out = state_ff.pincfg[spims_pkg::PIN_SS_OUT];
    assign global_ie = state_ff.pincfg[spims_pkg::PIN_GLOBAL_IE];

    ////////////////////////////////////////////////////////////////////////
    spims_rate_div u_rate_div (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_run    (state_ff.running),
        .i_rate   (state_ff.ctrl[spims_pkg::CTRL_RATE_HI:spims_pkg::CTRL_RATE_LO]),
        .i_double (state_ff.dbl),
        .o_tick   (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic       req;
        logic       acc;
        logic       busy;
        logic       sample;
        logic       in_bit;
        logic       slave_live;
        logic [7:0] shifted;
        req        = i_wb_cyc & i_wb_stb;
        acc        = req & state_ff.ack;
        busy       = state_ff.running | (state_ff.bit_cnt != 3'h0);
        sample     = 1'b0;
        in_bit     = 1'b0;
        slave_live = 1'b0;
        shifted    = 8'h00;
        nxt_state  = state_ff;

        // Bus answer: ack one cycle after the request, effects at the ack edge
        nxt_state.ack = req & ~state_ff.ack;
        if (req && !state_ff.ack) begin
            case (i_wb_adr)
                spims_pkg::ADDR_CONTROL: nxt_state.rdata = state_ff.ctrl;
                spims_pkg::ADDR_STATUS:  nxt_state.rdata = {state_ff.done,
                    state_ff.write_collision_flag, 5'h00, state_ff.dbl};
                spims_pkg::ADDR_DATA:    nxt_state.rdata = state_ff.rx_buf;
                spims_pkg::ADDR_PINCFG:  nxt_state.rdata = state_ff.pincfg;
                default:                 nxt_state.rdata = 8'h00;
            endcase
        end

        // Flag clearing: status read arms, data access clears
        if (acc && i_wb_adr == spims_pkg::ADDR_DATA) begin
            if (state_ff.arm_done) begin
                nxt_state.done = 1'b0;
            end
            if (state_ff.arm_write_collision_flag) begin
                nxt_state.done = 1'b0;
                nxt_state.write_collision_flag = 1'b0;
            end
            nxt_state.arm_done = 1'b0;
            nxt_state.arm_write_collision_flag = 1'b0;
        end
        if (acc && !i_wb_we && i_wb_adr == spims_pkg::ADDR_STATUS) begin
            nxt_state.arm_done = state_ff.done;
            nxt_state.arm_write_collision_flag = state_ff.write_collision_flag;
        end
        if (i_irq_vector_taken) begin
            nxt_state.done = 1'b0;
        end

        // Register writes
        if (acc && i_wb_we && i_wb_sel[0]) begin
            case (i_wb_adr)
                spims_pkg::ADDR_CONTROL: nxt_state.ctrl = i_wb_dat[7:0];
                spims_pkg::ADDR_STATUS:  nxt_state.dbl  = i_wb_dat[spims_pkg::STAT_DOUBLE];
                spims_pkg::ADDR_PINCFG:  nxt_state.pincfg = i_wb_dat[7:0];
                spims_pkg::ADDR_DATA: begin
                    if (busy) begin
                        // Single-buffered: the byte in flight is kept
                        nxt_state.write_collision_flag = 1'b1;
                    end else begin
                        nxt_state.sr      = i_wb_dat[7:0];
                        nxt_state.out_bit = top_bit(i_wb_dat[7:0], lsb_first);
                        if (port_en && is_master) begin
                            nxt_state.running  = 1'b1;
                            nxt_state.edge_cnt = 4'h0;
                        end
                    end
                end
                default: ;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // Master engine, stepped by the rate divider
        if (port_en && is_master && state_ff.running && tick) begin
            nxt_state.sck_out  = ~state_ff.sck_out;
            nxt_state.edge_cnt = state_ff.edge_cnt + 4'h1;
            sample  = state_ff.edge_cnt[0] == clock_phase_bit;
            shifted = state_ff.sr;
            if (sample) begin
                shifted      = shift_in(state_ff.sr, lsb_first, i_miso);
                nxt_state.sr = shifted;
            end else begin
                nxt_state.out_bit = top_bit(state_ff.sr, lsb_first);
            end
            if (state_ff.edge_cnt == spims_pkg::LAST_EDGE) begin
                nxt_state.running = 1'b0;
                nxt_state.rx_buf  = shifted;
                nxt_state.done    = 1'b1;
            end
        end

        // Slave engine, SCK taken as synchronous and edge-detected
        nxt_state.sck_prev = i_sck;
        nxt_state.ss_prev  = i_ss_n;
        slave_live = port_en && !is_master && !i_ss_n;
        if (slave_live && i_sck != state_ff.sck_prev) begin
            sample = (i_sck != clock_polarity_bit) != clock_phase_bit;
            in_bit = i_mosi;
            if (sample) begin
                shifted      = shift_in(state_ff.sr, lsb_first, in_bit);
                nxt_state.sr = shifted;
                if (state_ff.bit_cnt == spims_pkg::LAST_SAMPLE) begin
                    nxt_state.bit_cnt = 3'h0;
                    nxt_state.rx_buf  = shifted;
                    nxt_state.done    = 1'b1;
                end else begin
                    nxt_state.bit_cnt = state_ff.bit_cnt + 3'h1;
                end
            end else begin
                nxt_state.out_bit = top_bit(state_ff.sr, lsb_first);
            end
        end else if (slave_live && state_ff.bit_cnt == 3'h0 && !clock_phase_bit) begin
            // First bit must be on MISO before the first sampling edge
            nxt_state.out_bit = top_bit(state_ff.sr, lsb_first);
        end
        if (!is_master && i_ss_n && !state_ff.ss_prev) begin
            // Deselect mid-byte: drop the partial byte and resync the counter
            nxt_state.bit_cnt = 3'h0;
            if (state_ff.bit_cnt != 3'h0) begin
                nxt_state.sr = 8'h00;
            end
        end
        if (!is_master && i_ss_n) begin
            nxt_state.bit_cnt = 3'h0;
        end

        // Mode fault: another master pulled the select input low
        if (port_en && is_master && !ss_is_out && !i_ss_n) begin
            nxt_state.ctrl[spims_pkg::CTRL_MASTER] = 1'b0;
            nxt_state.running = 1'b0;
            nxt_state.done    = 1'b1;
        end

        // Disabled or idle: park SCK at its idle level
        // Next control word, so a disabling write stops a byte at once
        if (!nxt_state.ctrl[spims_pkg::CTRL_PORT_ENABLE]) begin
            nxt_state.running = 1'b0;
            nxt_state.bit_cnt = 3'h0;
        end
        if (!nxt_state.running) begin
            nxt_state.sck_out = nxt_state.ctrl[spims_pkg::CTRL_POLARITY];
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_ff        <= '0;
            state_ff.ctrl   <= spims_pkg::CONTROL_RESET;
            state_ff.pincfg <= spims_pkg::PINCFG_RESET;
            state_ff.done   <= spims_pkg::FLAG_RESET;
            state_ff.write_collision_flag   <= spims_pkg::FLAG_RESET;
            state_ff.ss_prev  <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_wb_ack = state_ff.ack;
    assign o_wb_dat = {24'h000000, state_ff.rdata};
    assign o_irq    = state_ff.ctrl[spims_pkg::CTRL_IRQ_ENABLE]
                      & state_ff.done & global_ie;

    assign o_sck  = state_ff.sck_out;
    assign o_mosi = state_ff.out_bit;
    assign o_miso = state_ff.out_bit;
    assign o_ss_n = state_ff.pincfg[spims_pkg::PIN_SS_LEVEL];

    // Pin directions: user-chosen in the driving role, forced input otherwise; SS is forced input only in an enabled slave
    assign o_sck_oe_n  = ~(port_en & is_master
                           & state_ff.pincfg[spims_pkg::PIN_SCK_OUT]);
    assign o_mosi_oe_n = ~(port_en & is_master
                           & state_ff.pincfg[spims_pkg::PIN_MOSI_OUT]);
    assign o_miso_oe_n = ~(port_en & ~is_master & ~i_ss_n
                           & state_ff.pincfg[spims_pkg::PIN_MISO_OUT]);
    assign o_ss_n_oe_n = ~(ss_is_out & ~(port_en & ~is_master));

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    AST_WB_ACK_PULSE: assert property (
        o_wb_ack |=> !o_wb_ack)
        else $error("Bus ack held longer than one cycle");

    AST_MODE_FAULT: assert property (
        port_en && is_master && !ss_is_out && !i_ss_n
        |=> !state_ff.ctrl[spims_pkg::CTRL_MASTER] && !state_ff.running)
        else $error("Mode fault did not drop to slave");

    AST_FAULT_FLAG: assert property (
        port_en && is_master && !ss_is_out && !i_ss_n |=> state_ff.done)
        else $error("Mode fault did not set done flag");

    AST_IRQ_RAISE: assert property (
        $rose(state_ff.done) && state_ff.ctrl[spims_pkg::CTRL_IRQ_ENABLE] && global_ie
        |-> o_irq)
        else $error("Interrupt not requested on completion");

    AST_DISABLED_QUIET: assert property (
        !port_en |-> o_sck_oe_n && o_mosi_oe_n && o_miso_oe_n && !state_ff.running)
        else $error("Disabled port drives SPI pins");

    AST_SLAVE_PASSIVE: assert property (
        port_en && !is_master && i_ss_n |-> o_miso_oe_n ##1 state_ff.bit_cnt == 3'h0)
        else $error("Deselected slave not passive");

    AST_SCK_IDLE: assert property (
        port_en && is_master && !state_ff.running && $stable(state_ff.ctrl)
        |-> o_sck == clock_polarity_bit)
        else $error("SCK not at idle level");

    AST_RESERVED_ZERO: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_adr == spims_pkg::ADDR_STATUS
        |=> o_wb_dat[5:1] == 5'h00)
        else $error("Reserved status bits not zero");

    AST_WRITE_COLLISION_FLAG_SET: assert property (
        o_wb_ack && i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0]
        && i_wb_adr == spims_pkg::ADDR_DATA && state_ff.running |=> state_ff.write_collision_flag)
        else $error("Busy data write did not flag collision");

    AST_MASTER_END: assert property (
        $fell(state_ff.running) && $past(tick) && is_master && port_en
        |-> state_ff.done && $past(state_ff.edge_cnt) == spims_pkg::LAST_EDGE)
        else $error("Master byte ended off the last edge");

    AST_SS_RISE_DROP: assert property (
        !is_master && i_ss_n && !state_ff.ss_prev && state_ff.bit_cnt != 3'h0
        |=> state_ff.sr == 8'h00 && state_ff.bit_cnt == 3'h0)
        else $error("Partial byte kept after deselect");

    AST_RXBUF_ON_DONE: assert property (
        $changed(state_ff.rx_buf) |-> state_ff.done)
        else $error("Receive buffer changed without a completed byte");

    AST_MOSI_STILL_ON_SAMPLE: assert property (
        port_en && is_master && state_ff.running && tick
        && state_ff.edge_cnt[0] == clock_phase_bit |=> $stable(o_mosi))
        else $error("Master MOSI moved on a sampling edge");

endmodule

//--- bench/spims_far_model.sv
// Far-side SPI slave model facing the port in master mode
`timescale 1ns/1ps
module spims_far_model (
    // Pins
    input  wire logic       i_clk,
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic       i_ss_n,
    // Mode {lsb first, polarity, phase} and byte to send
    input  wire logic [2:0] i_mode,
    input  wire logic [7:0] i_tx,
    output logic            o_miso,
    output logic [7:0]      o_rx
);
    logic [7:0] tx_sr = 8'h00;
    logic       flip  = 1'b0;
    int         n     = 0;
    // Released line toggles so a stale level never passes for data
    always @(posedge i_clk) flip <= ~flip;
    always @(negedge i_ss_n) begin
        tx_sr = i_tx;
        n = 0;
    end
    always @(i_sck) begin
        if (!i_ss_n) begin
            if ((i_sck != i_mode[1]) ^ i_mode[0]) begin
                o_rx = i_mode[2] ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
                n++;
            end else if (n > 0) begin
                tx_sr = i_mode[2] ? tx_sr >> 1 : tx_sr << 1;
            end
        end
    end
    assign o_miso = i_ss_n ? flip : (i_mode[2] ? tx_sr[0] : tx_sr[7]);
endmodule

//--- bench/tb_spims_port.sv
// Self-checking bench for the SPI master/slave port
`timescale 1ns/1ps
module tb_spims_port;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_wb_cyc = 1'b0;
    logic        i_wb_stb = 1'b0;
    logic        i_wb_we = 1'b0;
    logic [3:0]  i_wb_adr = 4'h0;
    logic [31:0] i_wb_dat = 32'h00000000;
    logic [3:0]  i_wb_sel = 4'hF;
    logic        i_irq_vector_taken = 1'b0;
    logic        ext_sck = 1'b0;
    logic        ext_mosi = 1'b0;
    logic        ext_ss_n = 1'b1;
    logic [31:0] o_wb_dat;
    logic        o_wb_ack, o_irq, o_sck, o_sck_oe_n, o_mosi, o_mosi_oe_n;
    logic        o_miso, o_miso_oe_n, o_ss_n, o_ss_n_oe_n, far_miso;
    logic        i_sck, i_mosi, i_miso, i_ss_n, dbl, ie, sck_q;
    logic [7:0]  rd, tx, ob, ctl, rx_got, far_rx, hd;
    logic [7:0]  far_tx = 8'h00;
    logic [2:0]  mode = 3'h0;
    logic [1:0]  rate;
    logic [15:0] expq[$];
    logic [15:0] note;
    int          num_errors = 0;
    int          compares = 0;
    int          seed = 32'hAD971F2C;
    int          half = 0;
    int          hcnt = 0;
    // Each party drives its pin only while its enable is low
    assign i_sck  = o_sck_oe_n ? ext_sck : o_sck;
    assign i_mosi = o_mosi_oe_n ? ext_mosi : o_mosi;
    assign i_miso = o_miso_oe_n ? far_miso : o_miso;
    assign i_ss_n = o_ss_n_oe_n ? ext_ss_n : o_ss_n;
    always #5 i_clk = ~i_clk;
    spims_port spims_port_i (.i_clk, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
        .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack, .i_irq_vector_taken, .o_irq, .i_sck,
        .o_sck, .o_sck_oe_n, .i_mosi, .o_mosi, .o_mosi_oe_n, .i_miso, .o_miso,
        .o_miso_oe_n, .i_ss_n, .o_ss_n, .o_ss_n_oe_n);
    spims_far_model spims_far_model_i (.i_clk(i_clk), .i_sck(i_sck), .i_mosi(i_mosi),
        .i_ss_n(i_ss_n), .i_mode(mode), .i_tx(far_tx), .o_miso(far_miso), .o_rx(far_rx));
    ////////////////////////////////////////////////////////////
    always @(posedge i_clk) begin
        sck_q <= o_sck;
        hcnt <= (o_sck !== sck_q) ? 1 : hcnt + 1;
        if (o_sck !== sck_q && o_sck_oe_n === 1'b0) half <= hcnt;
        if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) begin
            note = expq.pop_front();
            compares++;
            if ((o_wb_dat & {24'hFFFFFF, note[15:8]}) !== {24'h000000, note[7:0]}) begin
                num_errors++;
                $display("ERROR %0t read %h expected %h", $time, o_wb_dat, note[7:0]);
            end
        end
    end
    task automatic tally_and_finish();
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] e);
        compares++;
        if (got !== e) begin
            num_errors++;
            $display("ERROR %0t value %h expected %h", $time, got, e);
        end
    endtask
    // Mask 00 notes a read whose value is only used by the driver
    task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d,
                       input logic [7:0] m, input logic [7:0] e);
        int n;
        n = 0;
        if (!we) expq.push_back({m, e});
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= a;
        i_wb_dat <= {24'h000000, d};
        do begin
            @(posedge i_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 50);
        rd = o_wb_dat[7:0];
        if (n >= 50) begin
            num_errors++;
            tally_and_finish();
        end
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            bus(1'b0, spims_pkg::ADDR_STATUS, 8'h00, 8'h00, 8'h00);
            n++;
        end while (rd[7] !== 1'b1 && n < 1000);
        if (n >= 1000) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    // Mode 0, MSB first, SCK at clk/8
    task automatic ext_bits(input int n, input logic [7:0] b);
        for (int k = 0; k < n; k++) begin
            ext_mosi <= b[7-k];
            repeat (4) @(posedge i_clk);
            ext_sck <= 1'b1;
            rx_got = {rx_got[6:0], i_miso};
            repeat (4) @(posedge i_clk);
            ext_sck <= 1'b0;
        end
        ext_mosi <= ~ext_mosi;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        bus(1'b0, spims_pkg::ADDR_CONTROL, 8'h00, 8'hFF, spims_pkg::CONTROL_RESET);
        bus(1'b0, spims_pkg::ADDR_STATUS, 8'h00, 8'hFF, 8'h00);
        bus(1'b0, 4'h2, 8'h00, 8'hFF, 8'h00);
        for (int i = 0; i < 8; i++) begin
            mode = $random(seed);
            rate = $random(seed);
            dbl = $random(seed);
            ie = i[0];
            tx = $random(seed);
            ob = $random(seed);
            far_tx = tx;
            hd = (rate == 2'h3) ? 8'h40 : 8'h02 << (2 * rate);
            // New SCK idle level settles while the far side is deselected
            bus(1'b1, spims_pkg::ADDR_PINCFG, 8'h97, 8'h00, 8'h00);
            chk_val(i_ss_n, 8'h01);
            ctl = {ie, 1'b1, mode[2], 1'b1, mode[1:0], rate};
            bus(1'b1, spims_pkg::ADDR_CONTROL, ctl, 8'h00, 8'h00);
            bus(1'b1, spims_pkg::ADDR_STATUS, {7'h00, dbl}, 8'h00, 8'h00);
            bus(1'b1, spims_pkg::ADDR_PINCFG, 8'h87, 8'h00, 8'h00);
            chk_val(i_ss_n, 8'h00);
            bus(1'b1, spims_pkg::ADDR_DATA, ob, 8'h00, 8'h00);
            if (i == 0) bus(1'b1, spims_pkg::ADDR_DATA, ~ob, 8'h00, 8'h00);
            wait_done();
            chk_val(rd, {1'b1, i == 0, 5'h00, dbl});
            chk_val(o_irq, ie);
            chk_val(far_rx, ob);
            chk_val(half[7:0], dbl ? hd >> 1 : hd);
            chk_val(o_sck, mode[1]);
            if (ie) begin
                i_irq_vector_taken <= 1'b1;
                @(posedge i_clk);
                i_irq_vector_taken <= 1'b0;
                bus(1'b0, spims_pkg::ADDR_STATUS, 8'h00, 8'h80, 8'h00);
            end
            bus(1'b0, spims_pkg::ADDR_DATA, 8'h00, 8'hFF, tx);
            bus(1'b0, spims_pkg::ADDR_STATUS, 8'h00, 8'hFF, {7'h00, dbl});
        end
        bus(1'b1, spims_pkg::ADDR_PINCFG, 8'h86, 8'h00, 8'h00);
        bus(1'b1, spims_pkg::ADDR_CONTROL, 8'hD0, 8'h00, 8'h00);
        ext_ss_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk_val(o_irq, 8'h01);
        chk_val({o_sck_oe_n, o_mosi_oe_n}, 8'h03);
        ext_ss_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        bus(1'b0, spims_pkg::ADDR_CONTROL, 8'h00, 8'hFF, 8'hC0);
        bus(1'b0, spims_pkg::ADDR_STATUS, 8'h00, 8'h80, 8'h80);
        bus(1'b0, spims_pkg::ADDR_DATA, 8'h00, 8'h00, 8'h00);
        // Disabled master must not start on a data write
        bus(1'b1, spims_pkg::ADDR_PINCFG, 8'h07, 8'h00, 8'h00);
        bus(1'b1, spims_pkg::ADDR_CONTROL, 8'h10, 8'h00, 8'h00);
        bus(1'b1, spims_pkg::ADDR_DATA, 8'h5A, 8'h00, 8'h00);
        repeat (150) @(posedge i_clk);
        bus(1'b0, spims_pkg::ADDR_STATUS, 8'h00, 8'hC0, 8'h00);
        bus(1'b1, spims_pkg::ADDR_PINCFG, 8'h08, 8'h00, 8'h00);
        bus(1'b1, spims_pkg::ADDR_CONTROL, 8'h40, 8'h00, 8'h00);
        ext_bits(8, 8'hA5);
        bus(1'b0, spims_pkg::ADDR_STATUS, 8'h00, 8'hC0, 8'h00);
        chk_val(o_miso_oe_n, 8'h01);
        ext_ss_n <= 1'b0;
        ext_bits(3, 8'hFF);
        ext_ss_n <= 1'b1;
        tx = $random(seed);
        ob = $random(seed);
        bus(1'b1, spims_pkg::ADDR_DATA, tx, 8'h00, 8'h00);
        ext_ss_n <= 1'b0;
        @(posedge i_clk);
        chk_val({o_miso_oe_n, o_sck_oe_n, o_mosi_oe_n}, 8'h03);
        ext_bits(8, ob);
        repeat (8) @(posedge i_clk);
        ext_ss_n <= 1'b1;
        chk_val(rx_got, tx);
        bus(1'b0, spims_pkg::ADDR_STATUS, 8'h00, 8'hC0, 8'h80);
        bus(1'b0, spims_pkg::ADDR_DATA, 8'h00, 8'hFF, ob);
        tally_and_finish();
    end
endmodule
